// *** core/dif_core.sv ***
// Input capture, pointer initialisation, status registers and FIFO of the sample port
`timescale 1ns/1ns
module dif_core
  import dif_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        input_qualifier_clock,
  input  wire logic [31:0] data_bus,
  input  wire logic        frame_strobe,
  input  wire logic [1:0]  load_mode,
  input  wire logic        reference_sync_input,
  input  wire logic        data_rate_tick,
  input  wire logic        datapath_ready,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  output logic      [15:0] sample_i,
  output logic      [15:0] sample_q,
  output logic             sample_valid,
  output logic             capture_ready,
  output logic             fifo_warning
);

  typedef struct packed {
    logic                  dci_prev;
    logic                  sync_prev;
    logic [15:0]           hold_i;
    logic [15:0]           hold_q;
    logic                  q_second;
    logic                  pend_valid;
    logic [31:0]           pend_data;
    logic [2:0]            frame_cnt;
    logic                  frame_done;
    logic [7:0]            sync_ctrl;
    logic [7:0]            phase_ofs;
    logic                  reset_req;
    logic                  reset_ack;
    logic                  rel_pending;
    logic                  init_done;
    logic [7:0]            rdata;
    logic [15:0]           out_i;
    logic [15:0]           out_q;
    logic                  out_valid;
    logic                  cap_ready;
    logic                  warning;
  } dif_core_state_t;

  dif_core_state_t state;
  dif_core_state_t next_state;

  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [31:0]          fifo_out_data;
  logic                 fifo_pop;
  logic                 wr_load;
  logic                 rd_clear;
  logic [DIF_PTR_W-1:0] rd_ptr;
  logic [DIF_PTR_W-1:0] level;

  logic       dci_fall;
  logic       fifo_rate;
  logic       sync_edge;
  logic       frame_trig;
  logic       req_rise;
  logic       rd_wrap;
  logic [2:0] frame_next;

  dif_fifo #(
    .WIDTH (DIF_WORD_W),
    .DEPTH (DIF_DEPTH)
  ) u_fifo (
    .clock      (clock),
    .arst_n     (arst_n),
    .in_valid   (state.pend_valid),
    .in_data    (state.pend_data),
    .in_ready   (fifo_in_ready),
    .out_valid  (fifo_out_valid),
    .out_data   (fifo_out_data),
    .out_ready  (fifo_pop),
    .wr_load    (wr_load),
    .wr_value   (state.phase_ofs[DIF_PHASE_W-1:0]),
    .rd_clear   (rd_clear),
    .rd_ptr_out (rd_ptr),
    .level      (level)
  );

  always_comb begin
    next_state = state;

    dci_fall  = state.dci_prev && !input_qualifier_clock;
    fifo_rate = state.sync_ctrl[DIF_BIT_SYNC_EN] && !state.sync_ctrl[DIF_BIT_DATA_RATE];
    next_state.dci_prev  = input_qualifier_clock;
    next_state.sync_prev = reference_sync_input;

    // Sync edge polarity picked by control bit 3
    if (state.sync_ctrl[DIF_BIT_SYNC_EDGE]) begin
      sync_edge = state.sync_prev && !reference_sync_input;
    end else begin
      sync_edge = !state.sync_prev && reference_sync_input;
    end
    rd_clear = fifo_rate && sync_edge;

    // Pending word waits while the FIFO is full
    if (state.pend_valid && fifo_in_ready) begin
      next_state.pend_valid = 1'b0;
    end

    // Capture and formatting
    frame_trig = 1'b0;
    frame_next = state.frame_cnt;
    if (dci_fall) begin
      unique case (load_mode)
        DIF_MODE_WORD: begin
          if (frame_strobe) begin
            next_state.hold_i = data_bus[15:0];
          end else begin
            next_state.pend_valid = 1'b1;
            next_state.pend_data  = {state.hold_i, data_bus[15:0]};
          end
        end
        DIF_MODE_BYTE: begin
          if (frame_strobe) begin
            next_state.hold_i   = {state.hold_i[7:0], data_bus[7:0]};
            next_state.q_second = 1'b0;
          end else begin
            next_state.hold_q   = {state.hold_q[7:0], data_bus[7:0]};
            next_state.q_second = !state.q_second;
            if (state.q_second) begin
              next_state.pend_valid = 1'b1;
              next_state.pend_data  = {state.hold_i, state.hold_q[7:0], data_bus[7:0]};
            end
          end
        end
        default: begin
          next_state.pend_valid = 1'b1;
          next_state.pend_data  = data_bus;
        end
      endcase

      // Strobe held for a full I/Q load interval
      if (frame_strobe) begin
        if (state.frame_cnt != 3'h7) begin
          frame_next = state.frame_cnt + 3'h1;
        end
        if (frame_next >= dif_frame_len(load_mode) && !state.frame_done) begin
          frame_trig = 1'b1;
          next_state.frame_done = 1'b1;
        end
      end else begin
        frame_next = 3'h0;
        next_state.frame_done = 1'b0;
      end
      next_state.frame_cnt = frame_next;
    end

    // Register writes
    req_rise = 1'b0;
    if (reg_write) begin
      unique case (reg_addr)
        DIF_ADDR_SYNC_CTRL: next_state.sync_ctrl = reg_wdata;
        DIF_ADDR_PHASE_OFS: next_state.phase_ofs = reg_wdata;
        DIF_ADDR_INIT_STATUS: begin
          next_state.reset_req = reg_wdata[DIF_BIT_RESET_REQ];
          req_rise = reg_wdata[DIF_BIT_RESET_REQ] && !state.reset_req;
        end
        default: begin
        end
      endcase
    end
    next_state.reset_ack = state.reset_req;

    // Pointer initialisation
    fifo_pop = data_rate_tick && fifo_out_valid && datapath_ready;
    rd_wrap  = fifo_pop && (rd_ptr == DIF_LEVEL_HIGH);
    wr_load  = 1'b0;
    if (req_rise) begin
      next_state.rel_pending = 1'b1;
      next_state.init_done   = 1'b0;
    end
    if (frame_trig) begin
      if (fifo_rate) begin
        wr_load = 1'b1;
        next_state.init_done = 1'b1;
      end else begin
        next_state.rel_pending = 1'b1;
        next_state.init_done   = 1'b0;
      end
    end
    if (state.rel_pending && rd_wrap && !frame_trig && !req_rise) begin
      wr_load = 1'b1;
      next_state.rel_pending = 1'b0;
      next_state.init_done   = 1'b1;
    end

    // Output to the datapath
    if (fifo_pop) begin
      next_state.out_i     = fifo_out_data[31:16];
      next_state.out_q     = fifo_out_data[15:0];
      next_state.out_valid = 1'b1;
    end else if (datapath_ready) begin
      next_state.out_valid = 1'b0;
    end

    next_state.cap_ready = (level < DIF_LEVEL_BUSY) && !state.pend_valid;
    next_state.warning   = (level == DIF_LEVEL_LOW) || (level == DIF_LEVEL_HIGH);

    // Register reads
    if (reg_read) begin
      unique case (reg_addr)
        DIF_ADDR_SYNC_CTRL: next_state.rdata = state.sync_ctrl;
        DIF_ADDR_PHASE_OFS: next_state.rdata = state.phase_ofs;
        DIF_ADDR_INIT_STATUS: begin
          next_state.rdata = 8'h00;
          next_state.rdata[DIF_BIT_WARNING]   = state.warning;
          next_state.rdata[DIF_BIT_RESET_ACK] = state.reset_ack;
          next_state.rdata[DIF_BIT_RESET_REQ] = state.reset_req;
          next_state.rdata[DIF_BIT_INIT_DONE] = state.init_done;
        end
        DIF_ADDR_LEVEL: next_state.rdata = dif_thermo(level);
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state           <= '0;
      state.sync_ctrl <= DIF_RST_SYNC_CTRL;
      state.phase_ofs <= DIF_RST_PHASE_OFS;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata     = state.rdata;
  assign sample_i      = state.out_i;
  assign sample_q      = state.out_q;
  assign sample_valid  = state.out_valid;
  assign capture_ready = state.cap_ready;
  assign fifo_warning  = state.warning;

endmodule

// *** core/dif_pkg.sv ***
// Constants, types and helpers shared by the input FIFO block
package dif_pkg;

  localparam int unsigned DIF_CHAN_W    = 16;
  localparam int unsigned DIF_WORD_W    = 32;
  localparam int unsigned DIF_DEPTH     = 8;
  localparam int unsigned DIF_PTR_W     = 3;
  localparam int unsigned DIF_LEVEL_W   = 7;

  // Register offsets
  localparam logic [7:0] DIF_ADDR_SYNC_CTRL   = 8'h10;
  localparam logic [7:0] DIF_ADDR_PHASE_OFS   = 8'h17;
  localparam logic [7:0] DIF_ADDR_INIT_STATUS = 8'h18;
  localparam logic [7:0] DIF_ADDR_LEVEL       = 8'h19;

  // Reset values
  localparam logic [7:0] DIF_RST_SYNC_CTRL = 8'h00;
  localparam logic [7:0] DIF_RST_PHASE_OFS = 8'h04;

  // Field positions in sync_mode_control
  localparam int unsigned DIF_BIT_SYNC_EDGE = 3;
  localparam int unsigned DIF_BIT_DATA_RATE = 6;
  localparam int unsigned DIF_BIT_SYNC_EN   = 7;

  // Field positions in fifo_init_status
  localparam int unsigned DIF_BIT_INIT_DONE = 0;
  localparam int unsigned DIF_BIT_RESET_REQ = 1;
  localparam int unsigned DIF_BIT_RESET_ACK = 2;
  localparam int unsigned DIF_BIT_WARNING   = 7;

  // Phase offset field width
  localparam int unsigned DIF_PHASE_W = 3;

  // Warning levels
  localparam logic [2:0] DIF_LEVEL_LOW  = 3'h1;
  localparam logic [2:0] DIF_LEVEL_HIGH = 3'h7;

  // Level at which the capture-ready output drops
  localparam logic [2:0] DIF_LEVEL_BUSY = 3'h6;

  // Load modes
  typedef enum logic [1:0] {
    DIF_MODE_DUAL_WORD = 2'h0,
    DIF_MODE_WORD      = 2'h1,
    DIF_MODE_BYTE      = 2'h2
  } dif_mode_t;

  // Qualifier periods needed to load one complete I/Q pair
  localparam logic [2:0] DIF_FRAME_LEN_DUAL = 3'h1;
  localparam logic [2:0] DIF_FRAME_LEN_WORD = 3'h2;
  localparam logic [2:0] DIF_FRAME_LEN_BYTE = 3'h4;

  function automatic logic [2:0] dif_frame_len(input logic [1:0] mode);
    logic [2:0] len;
    len = DIF_FRAME_LEN_DUAL;
    if (mode == DIF_MODE_WORD) begin
      len = DIF_FRAME_LEN_WORD;
    end else if (mode == DIF_MODE_BYTE) begin
      len = DIF_FRAME_LEN_BYTE;
    end
    return len;
  endfunction

  // Thermometer code of a pointer difference
  function automatic logic [7:0] dif_thermo(input logic [2:0] level);
    logic [7:0] code;
    code = 8'h00;
    for (int i = 0; i < DIF_LEVEL_W; i++) begin
      code[i] = (3'(i) < level);
    end
    return code;
  endfunction

endpackage

// *** core/dif_fifo.sv ***
// Eight-entry sample FIFO with a loadable write pointer and a clearable read pointer
`timescale 1ns/1ns
module dif_fifo
  import dif_pkg::*;
#(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic                         clock,
  input  wire logic                         arst_n,
  input  wire logic                         in_valid,
  input  wire logic [WIDTH-1:0]             in_data,
  output logic                              in_ready,
  output logic                              out_valid,
  output logic [WIDTH-1:0]                  out_data,
  input  wire logic                         out_ready,
  input  wire logic                         wr_load,
  input  wire logic [$clog2(DEPTH)-1:0]     wr_value,
  input  wire logic                         rd_clear,
  output logic [$clog2(DEPTH)-1:0]          rd_ptr_out,
  output logic [$clog2(DEPTH)-1:0]          level
);

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
  } dif_fifo_state_t;

  dif_fifo_state_t state;
  dif_fifo_state_t next_state;

  logic [PW-1:0] wr_inc;
  logic [PW-1:0] rd_inc;

  always_comb begin
    wr_inc     = state.wr_ptr + PW'(1);
    rd_inc     = state.rd_ptr + PW'(1);
    level      = state.wr_ptr - state.rd_ptr;
    in_ready   = (wr_inc != state.rd_ptr);
    out_valid  = (state.wr_ptr != state.rd_ptr);
    out_data   = state.mem[state.rd_ptr];
    rd_ptr_out = state.rd_ptr;
    next_state = state;
    if (in_valid && in_ready) begin
      next_state.mem[state.wr_ptr] = in_data;
      next_state.wr_ptr            = wr_inc;
    end
    if (wr_load) begin
      next_state.wr_ptr = wr_value;
    end
    if (out_valid && out_ready) begin
      next_state.rd_ptr = rd_inc;
    end
    if (rd_clear) begin
      next_state.rd_ptr = '0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

// *** verification/dif_core_sva.sv ***
// Port assertions for the input FIFO block
`timescale 1ns/1ns
module dif_core_sva
  import dif_pkg::*;
(
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        input_qualifier_clock,
  input wire logic [31:0] data_bus,
  input wire logic        frame_strobe,
  input wire logic [1:0]  load_mode,
  input wire logic        reference_sync_input,
  input wire logic        data_rate_tick,
  input wire logic        datapath_ready,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic [15:0] sample_i,
  input wire logic [15:0] sample_q,
  input wire logic        sample_valid,
  input wire logic        capture_ready,
  input wire logic        fifo_warning
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_rdata_holds: assert property (!$past(reg_read) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_level_thermo: assert property (reg_read && reg_addr == DIF_ADDR_LEVEL |=>
    !reg_rdata[7] && (reg_rdata & (reg_rdata + 8'h01)) == 8'h00)
    else $error("level is not a thermometer code");
  a_valid_cause: assert property ($rose(sample_valid) |-> $past(data_rate_tick && datapath_ready))
    else $error("sample valid without a pop");
  a_sample_hold: assert property (!$past(data_rate_tick) |-> $stable({sample_i, sample_q}))
    else $error("sample changed without a tick");
  a_valid_drop: assert property (sample_valid && datapath_ready && !data_rate_tick |=>
    !sample_valid) else $error("sample valid not cleared");
  a_ack_rise: assert property (reg_write && reg_addr == DIF_ADDR_INIT_STATUS && reg_wdata[1]
    ##1 (!reg_write) [*3] ##0 (reg_read && reg_addr == DIF_ADDR_INIT_STATUS)
    |=> reg_rdata[DIF_BIT_RESET_ACK]) else $error("ack not raised");
  a_ack_fall: assert property (reg_write && reg_addr == DIF_ADDR_INIT_STATUS && !reg_wdata[1]
    ##1 (!reg_write) [*3] ##0 (reg_read && reg_addr == DIF_ADDR_INIT_STATUS)
    |=> !reg_rdata[DIF_BIT_RESET_ACK]) else $error("ack not dropped");
  a_offset_back: assert property (reg_write && reg_addr == DIF_ADDR_PHASE_OFS ##1 !reg_write
    ##1 (reg_read && reg_addr == DIF_ADDR_PHASE_OFS) |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3))
    else $error("phase offset readback wrong");
  a_mode_back: assert property (reg_write && reg_addr == DIF_ADDR_SYNC_CTRL ##1 !reg_write
    ##1 (reg_read && reg_addr == DIF_ADDR_SYNC_CTRL) |=>
    (reg_rdata & 8'hC8) == ($past(reg_wdata, 3) & 8'hC8)) else $error("sync control readback wrong");
  a_unmapped_zero: assert property (reg_read && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  c_pop: cover property (sample_valid && data_rate_tick);
  c_warning: cover property ($rose(fifo_warning));
  c_level_read: cover property (reg_read && reg_addr == DIF_ADDR_LEVEL);
endmodule

bind dif_core dif_core_sva dif_core_sva_i (.clock, .arst_n, .input_qualifier_clock, .data_bus,
  .frame_strobe, .load_mode, .reference_sync_input, .data_rate_tick, .datapath_ready, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .sample_i, .sample_q, .sample_valid,
  .capture_ready, .fifo_warning);

// *** verification/dif_source.sv ***
// Behavioural sample source driving the capture port
`timescale 1ns/1ns
module dif_source
  import dif_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [1:0]  load_mode,
  input  wire logic        capture_ready,
  output logic             qual_clock,
  output logic      [31:0] data_bus,
  output logic             frame_strobe
);
  initial begin
    qual_clock = 1'b0;
    data_bus = 32'h00000000;
    frame_strobe = 1'b0;
  end

  // Data and strobe stand across the falling qualifier transition
  task automatic unit(input logic [31:0] d, input logic f);
    @(negedge clock);
    qual_clock = 1'b1;
    data_bus = d;
    frame_strobe = f;
    @(negedge clock);
    qual_clock = 1'b0;
  endtask

  // Released bus shows the inverse of the last value
  task automatic idle();
    @(negedge clock);
    data_bus = ~data_bus;
    frame_strobe = 1'b0;
  endtask

  task automatic send_pair(input logic [15:0] i, input logic [15:0] q);
    // A source stuck here is caught by the bench's cycle ceiling
    while (!capture_ready) begin
      @(negedge clock);
    end
    case (load_mode)
      DIF_MODE_WORD: begin
        unit({16'h0000, i}, 1'b1);
        unit({16'h0000, q}, 1'b0);
      end
      DIF_MODE_BYTE: begin
        unit({24'h000000, i[15:8]}, 1'b1);
        unit({24'h000000, i[7:0]}, 1'b1);
        unit({24'h000000, q[15:8]}, 1'b0);
        unit({24'h000000, q[7:0]}, 1'b0);
      end
      default: unit({i, q}, 1'b0);
    endcase
    idle();
  endtask

  // Long strobe that requests a pointer reset
  task automatic strobe_hold(input int n);
    repeat (n) unit($urandom, 1'b1);
    idle();
  endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench of the input FIFO block against a reference queue
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module testbench
  import dif_pkg::*;
;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [1:0]  load_mode = 2'h0;
  logic        reference_sync_input = 1'b0;
  logic        data_rate_tick = 1'b0;
  logic        datapath_ready = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [7:0]  reg_rdata, rv;
  logic [15:0] sample_i, sample_q;
  logic        sample_valid, capture_ready, fifo_warning, qual_clock, frame_strobe;
  logic [31:0] data_bus, ev;
  logic [31:0] exp_q[$];
  logic [7:0]  ra [5] = '{8'h10, 8'h17, 8'h18, 8'h19, 8'h00};
  logic [7:0]  re [5] = '{DIF_RST_SYNC_CTRL, DIF_RST_PHASE_OFS, 8'h00, 8'h00, 8'h00};
  int          fails = 0, checked = 0, cycles = 0, pops = 0, n;
  bit          tick_en = 0, stall_en = 0, chk_data = 1, wrap_stop = 0;

  always #5 clock = ~clock;

  dif_core dif_core_i (.clock, .arst_n, .input_qualifier_clock(qual_clock), .data_bus,
    .frame_strobe, .load_mode, .reference_sync_input, .data_rate_tick, .datapath_ready,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .sample_i, .sample_q,
    .sample_valid, .capture_ready, .fifo_warning);
  dif_source dif_source_i (.clock, .load_mode, .capture_ready, .qual_clock, .data_bus,
    .frame_strobe);

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    rv = reg_rdata;
  endtask

  task automatic poll_ack(input logic e);
    int k;
    k = 0;
    do begin
      @(negedge clock);
      reg_rd(DIF_ADDR_INIT_STATUS);
      k++;
    end while (rv[DIF_BIT_RESET_ACK] !== e && k < 8);
    `CHK("reset ack", e, rv[DIF_BIT_RESET_ACK])
  endtask

  task automatic pair();
    logic [15:0] i, q;
    i = 16'($urandom);
    q = 16'($urandom);
    exp_q.push_back({i, q});
    dif_source_i.send_pair(i, q);
  endtask

  // Reference pop check, then random tick and stall for the next edge
  always @(negedge clock) begin
    if (data_rate_tick && datapath_ready && sample_valid) begin
      pops++;
      if (chk_data) begin
        ev = exp_q.pop_front();
        `CHK("sample", ev, {sample_i, sample_q})
      end
      if (wrap_stop && pops % 8 == 0) tick_en = 0;
    end
    data_rate_tick <= tick_en && ($urandom_range(2) == 0);
    datapath_ready <= !stall_en || ($urandom_range(3) != 0);
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    void'($urandom(53));
    repeat (3) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    for (int k = 0; k < 5; k++) begin
      reg_rd(ra[k]);
      `CHK("reset value", re[k], rv)
    end
    reg_wr(DIF_ADDR_LEVEL, 8'hFF);
    reg_rd(DIF_ADDR_LEVEL);
    `CHK("level write ignored", 8'h00, rv)
    tick_en = 1;
    stall_en = 1;
    for (int m = 0; m < 3; m++) begin
      load_mode = m[1:0];
      repeat (m == 0 ? 5 : 4) pair();
    end
    n = 0;
    while (exp_q.size() != 0 && n < 500) begin
      @(negedge clock);
      n++;
    end
    `CHK("drained", 0, exp_q.size())
    tick_en = 0;
    stall_en = 0;
    reg_wr(DIF_ADDR_SYNC_CTRL, 8'h80);
    reg_wr(DIF_ADDR_PHASE_OFS, 8'h07);
    reg_rd(DIF_ADDR_PHASE_OFS);
    `CHK("phase offset", 3'h7, rv[2:0])
    reg_wr(DIF_ADDR_INIT_STATUS, 8'h02);
    poll_ack(1'b1);
    reg_wr(DIF_ADDR_INIT_STATUS, 8'h00);
    poll_ack(1'b0);
    load_mode = DIF_MODE_DUAL_WORD;
    repeat (3) pair();
    reg_rd(DIF_ADDR_LEVEL);
    `CHK("level before wrap", 8'h07, rv)
    `CHK("capture ready", 1'b1, capture_ready)
    wrap_stop = 1;
    tick_en = 1;
    while (tick_en) begin
      @(negedge clock);
    end
    chk_data = 0;
    repeat (2) @(negedge clock);
    reg_rd(DIF_ADDR_LEVEL);
    `CHK("level after wrap", 8'h7F, rv)
    `CHK("warning pin", 1'b1, fifo_warning)
    `CHK("capture ready full", 1'b0, capture_ready)
    reg_rd(DIF_ADDR_INIT_STATUS);
    `CHK("warning bit", 1'b1, rv[DIF_BIT_WARNING])
    reg_wr(DIF_ADDR_PHASE_OFS, 8'h01);
    reference_sync_input = 1'b1;
    repeat (2) @(negedge clock);
    reference_sync_input = 1'b0;
    load_mode = DIF_MODE_WORD;
    dif_source_i.strobe_hold(2);
    repeat (3) @(negedge clock);
    reg_rd(DIF_ADDR_LEVEL);
    `CHK("absolute level", 8'h01, rv)
    `CHK("low warning pin", 1'b1, fifo_warning)
    reg_wr(DIF_ADDR_SYNC_CTRL, 8'hC8);
    reg_rd(DIF_ADDR_SYNC_CTRL);
    `CHK("sync control", 8'hC8, rv & 8'hC8)
    reg_wr(DIF_ADDR_PHASE_OFS, 8'h05);
    // A low first byte clears the strobe count without pushing a word
    load_mode = DIF_MODE_BYTE;
    dif_source_i.unit(32'h00000000, 1'b0);
    dif_source_i.strobe_hold(4);
    repeat (3) @(negedge clock);
    reg_rd(DIF_ADDR_LEVEL);
    `CHK("relative level", 8'h01, rv)
    reg_rd(DIF_ADDR_INIT_STATUS);
    `CHK("relative pending", 1'b0, rv[DIF_BIT_INIT_DONE])
    tick_en = 1;
    repeat (40) @(negedge clock);
    tick_en = 0;
    repeat (3) @(negedge clock);
    reg_rd(DIF_ADDR_LEVEL);
    `CHK("level emptied", 8'h00, rv)
    reg_wr(DIF_ADDR_SYNC_CTRL, 8'h88);
    reference_sync_input = 1'b1;
    repeat (2) @(negedge clock);
    reg_rd(DIF_ADDR_LEVEL);
    `CHK("rising sync ignored", 8'h00, rv)
    reference_sync_input = 1'b0;
    repeat (2) @(negedge clock);
    reg_rd(DIF_ADDR_LEVEL);
    `CHK("falling sync clears", 8'h01, rv)
    conclude();
  end
endmodule
